// *** inc/mcu_decoder_map.svh ***
// Register offsets, field positions, reset values and opcode codes
`ifndef MCU_DECODER_MAP_SVH
`define MCU_DECODER_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_INSTR 8'h04
`define OFS_ACC 8'h08
`define OFS_STATUS 8'h0c
`define OFS_PC 8'h10
`define OFS_TOS 8'h14
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_TO 3
`define ST_PD 4
`define ST_BUSY 8
`define CT_PSA 0
`define CT_GIE 1
`define RST_TO 1'b1
`define RST_PD 1'b1
`define QCYC_PER_INSTR 4
`define TIMER_ZERO_COUNT_ADDR 7'h01
`define PORT_ADDR 7'h06
`define W_RETURN 8'h08
`define W_INT_RETURN 8'h09
`define W_STANDBY 8'h63
`define W_WDT_RESTART 8'h64
`define OP_SPECIAL 4'h0
`define OP_CLEAR 4'h1
`define OP_SUB_F 4'h2
`define OP_DEC 4'h3
`define OP_OR_F 4'h4
`define OP_AND_F 4'h5
`define OP_XOR_F 4'h6
`define OP_ADD_F 4'h7
`define OP_MOVE 4'h8
`define OP_COMP 4'h9
`define OP_INC 4'ha
`define OP_DEC_SKIP 4'hb
`define OP_ROT_R 4'hc
`define OP_ROT_L 4'hd
`define OP_SWAP 4'he
`define OP_INC_SKIP 4'hf
`define GRP_BYTE 2'b00
`define GRP_BIT 2'b01
`define GRP_JUMP 2'b10
`define GRP_LIT 2'b11
`define LIT_OR 4'h8
`define LIT_AND 4'h9
`define LIT_XOR 4'ha
`endif

// *** inc/mcu_decoder_pkg.sv ***
// Types shared by the instruction decoder
package mcu_decoder_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} exec_e;
endpackage

// *** hw/mcu_instruction_decoder.sv ***
// Fourteen-bit instruction decoder and executor with APB register access
//
// How it works
// - Rotates go through carry, carry only
// - Register xor/or update zero flag only
// - Decrement/increment skip on zero, no flags
// - Bit ops: clear, set, skip clear/set
// - Literal or/xor into accumulator, zero flag
// - Literal minus accumulator sets C, DC, Z
// - Literal plus accumulator sets C, DC, Z
// - Return loading literal, two cycles
// - Interrupt return pops, two cycles
// - Subroutine return pops stack, two cycles
// - Standby word updates expiry and power-down
// - Watchdog restart word updates both bits
// - Program counter change or skip: two cycles
// - Timer count write clears assigned prescaler
// - Port read-modify-write uses pin levels
// - Destination bit picks accumulator or register
// - Instruction cycle is four clock periods
`timescale 1ns/1ns
`include "mcu_decoder_map.svh"

module mcu_instruction_decoder
  import mcu_decoder_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int QCYC = `QCYC_PER_INSTR
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_pins,
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic wdt_restart,
  output logic standby_enter,
  output logic prescaler_clear
);

  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int QW = $clog2(QCYC);
  localparam logic [QW-1:0] QLAST = QW'(QCYC - 1);

  generate
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0 || QCYC < 2)
    begin : g_bad
      $error("Stack depth must be a power of two, QCYC at least 2");
    end
  endgenerate

  typedef struct packed {
    exec_e st;
    logic [QW-1:0] q;
    logic [13:0] ir;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic to;
    logic pd;
    logic [10:0] pc;
    logic [STACK_DEPTH-1:0][10:0] stk;
    logic [SPW-1:0] sp;
    logic psa;
    logic gie;
    logic [7:0] pin_m;
    logic [7:0] pin_s;
    logic [31:0] rdata;
    logic err;
    logic fwe;
    logic [7:0] fwd;
    logic wdt;
    logic stby;
    logic pclr;
  } state_s;

  state_s s_reg;
  state_s s_next;

  ////////////////////////////////////////////////////////////////////////
  // Shared views of the state

  logic [7:0] f_op;
  logic [10:0] tos;
  logic commit;
  logic setup;
  logic access;
  logic busy;

  assign busy = (s_reg.st != ST_IDLE);
  assign commit = (s_reg.st == ST_EXEC) && (s_reg.q == QLAST);
  assign tos = s_reg.stk[s_reg.sp - SPW'(1)];
  // Port operand comes from synchronised pins
  assign f_op = (s_reg.ir[6:0] == `PORT_ADDR) ? s_reg.pin_s : file_rdata;
  assign setup = psel && !penable;
  assign access = psel && penable && !s_reg.err;

  assign pready = 1'b1;
  assign prdata = s_reg.rdata;
  assign pslverr = s_reg.err;
  assign file_addr = s_reg.ir[6:0];
  assign file_wdata = s_reg.fwd;
  assign file_we = s_reg.fwe;
  assign wdt_restart = s_reg.wdt;
  assign standby_enter = s_reg.stby;
  assign prescaler_clear = s_reg.pclr;

  // Sum with carry in; returns {carry, nibble carry, sum}
  function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'b0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'b0, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [7:0] res;
    logic [7:0] bm;
    logic [9:0] ar;
    logic wr_f;
    logic wr_w;
    logic bytew;
    logic zf;
    logic skip;
    logic pcchg;
    logic push;
    logic pop;
    logic [10:0] tgt;
    res = 8'h00;
    bm = 8'h01 << s_reg.ir[9:7];
    ar = 10'h000;
    wr_f = 1'b0;
    wr_w = 1'b0;
    bytew = 1'b0;
    zf = 1'b0;
    skip = 1'b0;
    pcchg = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tgt = s_reg.ir[10:0];
    s_next = s_reg;
    s_next.pin_m = port_pins;
    s_next.pin_s = s_reg.pin_m;
    s_next.fwe = 1'b0;
    s_next.wdt = 1'b0;
    s_next.stby = 1'b0;
    s_next.pclr = 1'b0;

    // APB setup phase: latch read data and refusal
    if (setup)
    begin
      s_next.err = 1'b0;
      s_next.rdata = 32'h0000_0000;
      case (paddr)
        `OFS_CTRL: s_next.rdata[`CT_GIE:`CT_PSA] = {s_reg.gie, s_reg.psa};
        `OFS_INSTR: s_next.rdata[13:0] = s_reg.ir;
        `OFS_ACC: s_next.rdata[7:0] = s_reg.acc;
        `OFS_STATUS:
        begin
          s_next.rdata[`ST_PD:`ST_C] = {s_reg.pd, s_reg.to, s_reg.z, s_reg.dc, s_reg.c};
          s_next.rdata[`ST_BUSY] = busy;
        end
        `OFS_PC: s_next.rdata[10:0] = s_reg.pc;
        `OFS_TOS: s_next.rdata[10:0] = tos;
        default: s_next.err = 1'b1;
      endcase
      if (pwrite && busy && paddr != `OFS_CTRL)
        s_next.err = 1'b1;
    end

    // APB access phase: writes take effect
    if (access && pwrite)
    begin
      case (paddr)
        `OFS_CTRL:
        begin
          s_next.psa = pwdata[`CT_PSA];
          s_next.gie = pwdata[`CT_GIE];
        end
        `OFS_INSTR:
        begin
          s_next.ir = pwdata[13:0];
          s_next.st = ST_EXEC;
          s_next.q = '0;
        end
        `OFS_ACC: s_next.acc = pwdata[7:0];
        `OFS_STATUS:
        begin
          s_next.c = pwdata[`ST_C];
          s_next.dc = pwdata[`ST_DC];
          s_next.z = pwdata[`ST_Z];
        end
        `OFS_PC: s_next.pc = pwdata[10:0];
        default: ;
      endcase
    end

    // Four clock periods per instruction cycle
    if (busy)
      s_next.q = (s_reg.q == QLAST) ? '0 : s_reg.q + QW'(1);
    if (s_reg.st == ST_NOP && s_reg.q == QLAST)
      s_next.st = ST_IDLE;

    if (commit)
    begin
      case (s_reg.ir[13:12])
        `GRP_BYTE:
        begin
          case (s_reg.ir[11:8])
            `OP_SPECIAL:
            begin
              if (s_reg.ir[7])
              begin
                res = s_reg.acc;
                wr_f = 1'b1;
              end
              else
              begin
                case (s_reg.ir[7:0])
                  `W_RETURN: pop = 1'b1;
                  `W_INT_RETURN:
                  begin
                    pop = 1'b1;
                    s_next.gie = 1'b1;
                  end
                  `W_STANDBY:
                  begin
                    s_next.to = 1'b1;
                    s_next.pd = 1'b0;
                    s_next.stby = 1'b1;
                  end
                  `W_WDT_RESTART:
                  begin
                    s_next.to = 1'b1;
                    s_next.pd = 1'b1;
                    s_next.wdt = 1'b1;
                  end
                  default: ;
                endcase
              end
            end
            `OP_CLEAR:
            begin
              zf = 1'b1;
              wr_f = s_reg.ir[7];
              wr_w = !s_reg.ir[7];
            end
            `OP_SUB_F:
            begin
              ar = addc(f_op, ~s_reg.acc, 1'b1);
              res = ar[7:0];
              {s_next.c, s_next.dc} = ar[9:8];
              zf = 1'b1;
              bytew = 1'b1;
            end
            `OP_ADD_F:
            begin
              ar = addc(f_op, s_reg.acc, 1'b0);
              res = ar[7:0];
              {s_next.c, s_next.dc} = ar[9:8];
              zf = 1'b1;
              bytew = 1'b1;
            end
            `OP_DEC, `OP_INC, `OP_AND_F, `OP_MOVE, `OP_COMP:
            begin
              case (s_reg.ir[11:8])
                `OP_DEC: res = f_op - 8'h01;
                `OP_INC: res = f_op + 8'h01;
                `OP_AND_F: res = f_op & s_reg.acc;
                `OP_COMP: res = ~f_op;
                default: res = f_op;
              endcase
              zf = 1'b1;
              bytew = 1'b1;
            end
            `OP_OR_F, `OP_XOR_F:
            begin
              res = s_reg.ir[9] ? f_op ^ s_reg.acc : f_op | s_reg.acc;
              zf = 1'b1;
              bytew = 1'b1;
            end
            `OP_DEC_SKIP, `OP_INC_SKIP:
            begin
              res = s_reg.ir[10] ? f_op + 8'h01 : f_op - 8'h01;
              skip = (res == 8'h00);
              bytew = 1'b1;
            end
            `OP_ROT_L:
            begin
              res = {f_op[6:0], s_reg.c};
              s_next.c = f_op[7];
              bytew = 1'b1;
            end
            `OP_ROT_R:
            begin
              res = {s_reg.c, f_op[7:1]};
              s_next.c = f_op[0];
              bytew = 1'b1;
            end
            `OP_SWAP:
            begin
              res = {f_op[3:0], f_op[7:4]};
              bytew = 1'b1;
            end
            default: ;
          endcase
        end
        `GRP_BIT:
        begin
          case (s_reg.ir[11:10])
            2'b00:
            begin
              res = f_op & ~bm;
              wr_f = 1'b1;
            end
            2'b01:
            begin
              res = f_op | bm;
              wr_f = 1'b1;
            end
            2'b10: skip = ((f_op & bm) == 8'h00);
            default: skip = ((f_op & bm) != 8'h00);
          endcase
        end
        `GRP_JUMP:
        begin
          pcchg = 1'b1;
          push = !s_reg.ir[11];
        end
        default:
        begin
          casez (s_reg.ir[11:8])
            4'b00??: res = s_reg.ir[7:0];
            4'b01??:
            begin
              res = s_reg.ir[7:0];
              pop = 1'b1;
            end
            `LIT_OR:
            begin
              res = s_reg.acc | s_reg.ir[7:0];
              zf = 1'b1;
            end
            `LIT_AND:
            begin
              res = s_reg.acc & s_reg.ir[7:0];
              zf = 1'b1;
            end
            `LIT_XOR:
            begin
              res = s_reg.acc ^ s_reg.ir[7:0];
              zf = 1'b1;
            end
            // Reserved literal code: no-op
            4'b1011: ;
            4'b110?:
            begin
              ar = addc(s_reg.ir[7:0], ~s_reg.acc, 1'b1);
              res = ar[7:0];
              {s_next.c, s_next.dc} = ar[9:8];
              zf = 1'b1;
            end
            default:
            begin
              ar = addc(s_reg.ir[7:0], s_reg.acc, 1'b0);
              res = ar[7:0];
              {s_next.c, s_next.dc} = ar[9:8];
              zf = 1'b1;
            end
          endcase
          wr_w = (s_reg.ir[11:8] != 4'b1011);
        end
      endcase

      if (bytew)
      begin
        wr_f = s_reg.ir[7];
        wr_w = !s_reg.ir[7];
      end
      if (zf)
        s_next.z = (res == 8'h00);
      if (wr_w)
        s_next.acc = res;
      if (wr_f)
      begin
        s_next.fwe = 1'b1;
        s_next.fwd = res;
        s_next.pclr = s_reg.psa && (s_reg.ir[6:0] == `TIMER_ZERO_COUNT_ADDR);
      end
      if (pop)
      begin
        pcchg = 1'b1;
        tgt = tos;
        s_next.sp = s_reg.sp - SPW'(1);
      end
      if (push)
      begin
        s_next.stk[s_reg.sp] = s_reg.pc + 11'd1;
        s_next.sp = s_reg.sp + SPW'(1);
      end
      s_next.pc = pcchg ? tgt : s_reg.pc + (skip ? 11'd2 : 11'd1);
      s_next.st = (pcchg || skip) ? ST_NOP : ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.to <= `RST_TO;
      s_reg.pd <= `RST_PD;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  exec_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == `OFS_INSTR) |=> (s_reg.st == ST_EXEC)[*4])
    else $error("Instruction cycle not four clocks");

  jump_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && s_reg.ir[13:12] == `GRP_JUMP) |=> (s_reg.st == ST_NOP)[*4] ##1 !busy)
    else $error("Jump did not take two cycles");

  return_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && s_reg.ir == {6'h00, `W_RETURN}) |=> (s_reg.pc == $past(tos)))
    else $error("Return did not restore pc");

  skip_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && s_reg.ir[13:8] == {`GRP_BYTE, `OP_INC_SKIP} && f_op == 8'hff)
    |=> (s_reg.st == ST_NOP && s_reg.z == $past(s_reg.z)))
    else $error("Increment skip wrong");

  standby_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && s_reg.ir == {6'h00, `W_STANDBY}) |=> (standby_enter && s_reg.to && !s_reg.pd))
    else $error("Standby did not update status");

  wdt_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && s_reg.ir == {6'h00, `W_WDT_RESTART}) |=> (wdt_restart && s_reg.to && s_reg.pd))
    else $error("Watchdog restart did not update status");

  rot_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && s_reg.ir[13:8] == {`GRP_BYTE, `OP_ROT_L})
    |=> (s_reg.c == $past(f_op[7]) && s_reg.z == $past(s_reg.z)))
    else $error("Rotate left carry wrong");

  presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && s_reg.psa && s_reg.ir[13:7] == {`GRP_BIT, 2'b01, 3'b000}
     && s_reg.ir[6:0] == `TIMER_ZERO_COUNT_ADDR) |=> (prescaler_clear && file_we))
    else $error("Prescaler not cleared");

endmodule

// *** tb/file_reg_model.sv ***
// Behavioural file register array on the far side of the decoder
`timescale 1ns/1ns

module file_reg_model
(
  input wire logic pclk,
  input wire logic [6:0] file_addr,
  output logic [7:0] file_rdata,
  input wire logic [7:0] file_wdata,
  input wire logic file_we
);
  logic [7:0] mem [128];

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'ha5;
  end

  assign file_rdata = mem[file_addr];

  always @(posedge pclk)
  begin
    if (file_we)
      mem[file_addr] <= file_wdata;
  end
endmodule

// *** tb/mcu_instruction_decoder_test.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ns
`include "mcu_decoder_map.svh"

module mcu_instruction_decoder_test;
  typedef struct {logic [31:0] st, acc, mem, ins, ae, me, se, pd;} row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, file_we, err;
  logic wdt_restart, standby_enter, prescaler_clear;
  logic [7:0] paddr, port_pins, file_rdata, file_wdata;
  logic [6:0] file_addr;
  logic [31:0] pwdata, prdata, v, pc0;
  int miscompares, checks, cyc, base, n_wdt, n_sb, n_pre;
  row_s rows[$];

  mcu_instruction_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pins(port_pins), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we),
    .wdt_restart(wdt_restart), .standby_enter(standby_enter),
    .prescaler_clear(prescaler_clear));

  file_reg_model u_files (.pclk(pclk), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Pulse counters and hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    n_wdt <= n_wdt + (wdt_restart === 1'b1);
    n_sb <= n_sb + (standby_enter === 1'b1);
    n_pre <= n_pre + (prescaler_clear === 1'b1);
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask

  // Back-to-back APB transfer, entered right after a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  task idle_wait();
    logic [31:0] s;
    s = 32'h100;
    while (s[`ST_BUSY] !== 1'b0)
      rd(`OFS_STATUS, s);
  endtask

  // Execute one word; two-cycle words must take four clocks more
  task run(input logic [31:0] ins, input logic two);
    time t0;
    int n;
    t0 = $time;
    wr(`OFS_INSTR, ins);
    idle_wait();
    n = int'(($time - t0) / 10);
    if (base == 0)
      base = n;
    else
      chk(32'(n - base), two ? 32'h4 : 32'h0);
  endtask

  function automatic void add(logic [7:0] s, a, m, logic [13:0] i, logic [7:0] ae, me, se,
    int p);
    rows.push_back('{32'(s), 32'(a), 32'(m), 32'(i), 32'(ae), 32'(me), 32'(se), 32'(p)});
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    port_pins = 8'h5a;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_STATUS, v);
    chk(v, 32'h18);
    rd(8'h20, v);
    chk({31'h0, err}, 32'h1);
    chk(v, 32'h0);
    run(32'h0, 1'b0);
    add(8'h0, 8'h10, 8'h0, 14'h3e15, 8'h25, 8'h0, 8'h0, 1);
    add(8'h0, 8'h10, 8'h0, 14'h3ff0, 8'h00, 8'h0, 8'h5, 1);
    add(8'h0, 8'h01, 8'h0, 14'h3e0f, 8'h10, 8'h0, 8'h2, 1);
    add(8'h0, 8'h01, 8'h0, 14'h3c01, 8'h00, 8'h0, 8'h7, 1);
    add(8'h0, 8'h01, 8'h0, 14'h3d00, 8'hff, 8'h0, 8'h0, 1);
    add(8'h0, 8'h01, 8'h0, 14'h3c10, 8'h0f, 8'h0, 8'h1, 1);
    add(8'h3, 8'h00, 8'h0, 14'h3800, 8'h00, 8'h0, 8'h7, 1);
    add(8'h4, 8'h0f, 8'h0, 14'h3aff, 8'hf0, 8'h0, 8'h0, 1);
    add(8'h0, 8'ha3, 8'h0, 14'h395f, 8'h03, 8'h0, 8'h0, 1);
    add(8'h7, 8'h00, 8'h0, 14'h3055, 8'h55, 8'h0, 8'h7, 1);
    add(8'h7, 8'h10, 8'h0, 14'h3b55, 8'h10, 8'h0, 8'h7, 1);
    add(8'h0, 8'h00, 8'h81, 14'h0da0, 8'h00, 8'h02, 8'h1, 1);
    add(8'h7, 8'h00, 8'h02, 14'h0c20, 8'h81, 8'h02, 8'h6, 1);
    add(8'h3, 8'h81, 8'h81, 14'h0620, 8'h00, 8'h81, 8'h7, 1);
    add(8'h7, 8'h0f, 8'hf0, 14'h04a0, 8'h0f, 8'hff, 8'h3, 1);
    add(8'h7, 8'h00, 8'h05, 14'h0ba0, 8'h00, 8'h04, 8'h7, 1);
    add(8'h0, 8'h00, 8'h01, 14'h0ba0, 8'h00, 8'h00, 8'h0, 2);
    add(8'h0, 8'h44, 8'hff, 14'h0f20, 8'h00, 8'hff, 8'h0, 2);
    add(8'h0, 8'h08, 8'h08, 14'h0720, 8'h10, 8'h08, 8'h2, 1);
    add(8'h0, 8'h01, 8'h01, 14'h02a0, 8'h01, 8'h00, 8'h7, 1);
    add(8'h0, 8'h0f, 8'h3c, 14'h0520, 8'h0c, 8'h3c, 8'h0, 1);
    add(8'h0, 8'h00, 8'hff, 14'h09a0, 8'h00, 8'h00, 8'h4, 1);
    add(8'h7, 8'h00, 8'h12, 14'h0e20, 8'h21, 8'h12, 8'h7, 1);
    add(8'h0, 8'h00, 8'h55, 14'h01a0, 8'h00, 8'h00, 8'h4, 1);
    add(8'h0, 8'h3c, 8'h00, 14'h00a0, 8'h3c, 8'h3c, 8'h0, 1);
    add(8'h7, 8'h00, 8'h00, 14'h15a0, 8'h00, 8'h08, 8'h7, 1);
    add(8'h7, 8'h00, 8'hff, 14'h13a0, 8'h00, 8'h7f, 8'h7, 1);
    add(8'h0, 8'h00, 8'h02, 14'h1820, 8'h00, 8'h02, 8'h0, 2);
    add(8'h0, 8'h00, 8'h02, 14'h1ca0, 8'h00, 8'h02, 8'h0, 2);
    add(8'h0, 8'h00, 8'h02, 14'h1c20, 8'h00, 8'h02, 8'h0, 1);
    foreach (rows[i])
    begin
      wr(`OFS_STATUS, rows[i].st);
      wr(`OFS_ACC, rows[i].acc);
      u_files.mem[7'h20] = rows[i].mem[7:0];
      rd(`OFS_PC, pc0);
      run(rows[i].ins, rows[i].pd == 2);
      rd(`OFS_ACC, v);
      chk(v, rows[i].ae);
      chk({24'h0, u_files.mem[7'h20]}, rows[i].me);
      rd(`OFS_STATUS, v);
      chk(v & 32'h7, rows[i].se);
      rd(`OFS_PC, v);
      chk(v, (pc0 + rows[i].pd) & 32'h7ff);
    end
    run(32'h2923, 1'b1);
    rd(`OFS_PC, v);
    chk(v, 32'h123);
    run(32'h2050, 1'b1);
    rd(`OFS_PC, v);
    chk(v, 32'h50);
    rd(`OFS_TOS, v);
    chk(v, 32'h124);
    run(32'h3755, 1'b1);
    rd(`OFS_ACC, v);
    chk(v, 32'h55);
    rd(`OFS_PC, v);
    chk(v, 32'h124);
    run(32'h2050, 1'b1);
    run(32'h0008, 1'b1);
    rd(`OFS_PC, v);
    chk(v, 32'h125);
    wr(`OFS_CTRL, 32'h0);
    run(32'h2050, 1'b1);
    run(32'h0009, 1'b1);
    rd(`OFS_PC, v);
    chk(v, 32'h126);
    rd(`OFS_CTRL, v);
    chk(v & 32'h2, 32'h2);
    run(32'h0064, 1'b0);
    chk(n_wdt, 1);
    run(32'h0063, 1'b0);
    chk(n_sb, 1);
    rd(`OFS_STATUS, v);
    chk(v & 32'h18, 32'h08);
    run(32'h0064, 1'b0);
    rd(`OFS_STATUS, v);
    chk(v & 32'h18, 32'h18);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_ACC, 32'h77);
    run(32'h0081, 1'b0);
    chk(n_pre, 1);
    chk({24'h0, u_files.mem[7'h1]}, 32'h77);
    run(32'h0801, 1'b0);
    chk(n_pre, 1);
    run(32'h1401, 1'b0);
    chk(n_pre, 2);
    wr(`OFS_CTRL, 32'h0);
    run(32'h0081, 1'b0);
    chk(n_pre, 2);
    u_files.mem[7'h6] = 8'hff;
    run(32'h0886, 1'b0);
    chk({24'h0, u_files.mem[7'h6]}, 32'h5a);
    // Accumulator write refused while busy
    wr(`OFS_ACC, 32'h11);
    wr(`OFS_INSTR, 32'h2800);
    wr(`OFS_ACC, 32'h99);
    chk({31'h0, err}, 32'h1);
    idle_wait();
    rd(`OFS_ACC, v);
    chk(v, 32'h11);
    complete_run();
  end
endmodule
